// ---- hw/sync_burst_sram_pkg.sv ----
`default_nettype none
package sync_burst_sram_pkg;

  // Array geometry
  localparam int ADDR_W = 18;
  localparam int WORDS = 262144;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int CNT_W = 2;

  // Read-data trace buffer
  localparam int TRACE_DEPTH = 32;

  // Reset values and burst count step
  localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;

  // Burst context: deselected, or a selected burst in progress
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACTIVE = 2'b10
  } burst_state_t;

endpackage
`default_nettype wire

// ---- hw/sync_burst_sram_port.sv ----
`timescale 1ns/100ps
`default_nettype none

module burst_trace_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE = (PTR_W)'(1);
  localparam logic [PTR_W:0] CNT_ONE = (PTR_W+1)'(1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != DEPTH_CNT);
  assign outValid = (count_q != '0);
  assign outData = store[rdPtr_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + PTR_ONE;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + PTR_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + CNT_ONE;
    end else if (pop && !push) begin
      count_q <= count_q - CNT_ONE;
    end
  end

endmodule

// Notes on behaviour
// - Address, data and controls except output enable and order select registered on clk.
// - Array holds 256K words of 18 bits in two 9-bit lanes a and b.
// - Two-bit burst counter forms low address bits after the first beat.
// - Controller strobe low aborts burst, loads address, starts read, write or deselect.
// - Processor strobe low aborts burst, loads address, starts read or deselect.
// - Processor strobe is ignored while chip select one is high.
// - Burst step low advances the count in the selected order.
// - Order select is used unregistered; low linear, high interleaved; held steady.
// - Writes complete on the clock edge with no external write pulse.
// - Each lane written only when its byte write and write enable are low, or global write is low.
// - Global write, or both byte writes with write enable, writes both lanes.
// - Read data appears after the edge following the registered read.
// - Output enable acts at once: low drives data pins in the cycle after a read, high releases them.
// - Selected only when chip selects one low, two high, three low.
// - Write when any byte write with write enable low, or global write low.
// - Linear adds beat count modulo four; interleaved XORs start with count.
module sync_burst_sram_port (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Address and burst control
  input wire logic [sync_burst_sram_pkg::ADDR_W-1:0] addressInputs,
  input wire logic procAddrStrobeN,
  input wire logic ctrlAddrStrobeN,
  input wire logic burstStepN,
  input wire logic burstOrderSel,
  // Chip selects
  input wire logic chipSelOneN,
  input wire logic chipSelTwo,
  input wire logic chipSelThreeN,
  // Write control
  input wire logic byteWriteLaneAN,
  input wire logic byteWriteLaneBN,
  input wire logic globalWriteN,
  input wire logic writeEnableN,
  // Data pins, lane a in the low bits
  input wire logic [sync_burst_sram_pkg::DATA_W-1:0] dataLanesIn,
  output wire logic [sync_burst_sram_pkg::DATA_W-1:0] dataLanesOut,
  output logic dataLanesOe,
  input wire logic outputEnableN,
  // Read-data trace stream
  output logic traceInReady,
  output logic traceValid,
  input wire logic traceReady,
  output logic [sync_burst_sram_pkg::DATA_W-1:0] traceData
);

  localparam int LANE_W = sync_burst_sram_pkg::LANE_W;
  localparam int CNT_W = sync_burst_sram_pkg::CNT_W;
  localparam int ADDR_W = sync_burst_sram_pkg::ADDR_W;

  // Pins captured on the rising edge
  logic [ADDR_W-1:0] addr_q;
  logic procStrobeN_q;
  logic ctrlStrobeN_q;
  logic stepN_q;
  logic sel1N_q;
  logic sel2_q;
  logic sel3N_q;
  logic bwAN_q;
  logic bwBN_q;
  logic gwN_q;
  logic weN_q;
  logic [sync_burst_sram_pkg::DATA_W-1:0] wrData_q;

  // Burst context
  sync_burst_sram_pkg::burst_state_t state_q;
  sync_burst_sram_pkg::burst_state_t state_d;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] base_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic drive_q;
  logic readDone_q;

  logic chipOn;
  logic procStart;
  logic ctrlStart;
  logic isWrite;
  logic [sync_burst_sram_pkg::LANES-1:0] laneWr;
  logic doRead;
  logic doWrite;
  logic [CNT_W-1:0] lowBits;
  logic [ADDR_W-1:0] accAddr;

  always_ff @(posedge clk) begin
    if (srst) begin
      procStrobeN_q <= 1'b1;
      ctrlStrobeN_q <= 1'b1;
      stepN_q <= 1'b1;
      sel1N_q <= 1'b1;
      sel2_q <= 1'b0;
      sel3N_q <= 1'b1;
      bwAN_q <= 1'b1;
      bwBN_q <= 1'b1;
      gwN_q <= 1'b1;
      weN_q <= 1'b1;
      addr_q <= sync_burst_sram_pkg::ADDR_RESET;
      wrData_q <= sync_burst_sram_pkg::DATA_RESET;
    end else begin
      procStrobeN_q <= procAddrStrobeN;
      ctrlStrobeN_q <= ctrlAddrStrobeN;
      stepN_q <= burstStepN;
      sel1N_q <= chipSelOneN;
      sel2_q <= chipSelTwo;
      sel3N_q <= chipSelThreeN;
      bwAN_q <= byteWriteLaneAN;
      bwBN_q <= byteWriteLaneBN;
      gwN_q <= globalWriteN;
      weN_q <= writeEnableN;
      addr_q <= addressInputs;
      wrData_q <= dataLanesIn;
    end
  end

  assign chipOn = !sel1N_q && sel2_q && !sel3N_q;
  assign procStart = !procStrobeN_q && !sel1N_q;
  assign ctrlStart = !ctrlStrobeN_q && !procStart;
  assign isWrite = !gwN_q || (!weN_q && (!bwAN_q || !bwBN_q));
  assign laneWr[0] = !gwN_q || (!weN_q && !bwAN_q);
  assign laneWr[1] = !gwN_q || (!weN_q && !bwBN_q);

  // A processor strobe never writes: its first beat is always a read
  always_comb begin
    state_d = state_q;
    base_d = base_q;
    cnt_d = cnt_q;
    doRead = 1'b0;
    doWrite = 1'b0;
    if (procStart || ctrlStart) begin
      base_d = addr_q;
      cnt_d = sync_burst_sram_pkg::CNT_RESET;
      if (chipOn) begin
        state_d = sync_burst_sram_pkg::ST_ACTIVE;
        doWrite = ctrlStart && isWrite;
        doRead = !doWrite;
      end else begin
        state_d = sync_burst_sram_pkg::ST_IDLE;
      end
    end else if (state_q == sync_burst_sram_pkg::ST_ACTIVE) begin
      if (!stepN_q) begin
        cnt_d = cnt_q + sync_burst_sram_pkg::CNT_STEP;
      end
      doWrite = isWrite;
      doRead = !isWrite;
    end
  end

  // Order select is sampled live, so a change mid-burst reorders it at once
  assign lowBits = burstOrderSel ? (base_d[CNT_W-1:0] ^ cnt_d)
                                 : (base_d[CNT_W-1:0] + cnt_d);
  assign accAddr = {base_d[ADDR_W-1:CNT_W], lowBits};

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= sync_burst_sram_pkg::ST_IDLE;
      base_q <= sync_burst_sram_pkg::ADDR_RESET;
      cnt_q <= sync_burst_sram_pkg::CNT_RESET;
    end else begin
      state_q <= state_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end

  // Pins are driven only after a read and only while output enable is low
  always_ff @(posedge clk) begin
    if (srst) begin
      drive_q <= 1'b0;
      readDone_q <= 1'b0;
    end else begin
      drive_q <= doRead;
      readDone_q <= doRead;
    end
  end

  assign dataLanesOe = drive_q && !outputEnableN;

  // One array per lane keeps each lane's write strobe independent
  for (genvar l = 0; l < sync_burst_sram_pkg::LANES; l++) begin : g_lane
    logic [LANE_W-1:0] laneMem [0:sync_burst_sram_pkg::WORDS-1];
    logic [LANE_W-1:0] laneOut_q;

    always_ff @(posedge clk) begin
      if (doWrite && laneWr[l]) begin
        laneMem[accAddr] <= wrData_q[l*LANE_W +: LANE_W];
      end
    end

    always_ff @(posedge clk) begin
      if (doRead) begin
        laneOut_q <= laneMem[accAddr];
      end
    end

    assign dataLanesOut[l*LANE_W +: LANE_W] = laneOut_q;
  end

  // Trace copies every read beat; when full, beats are dropped and ready shows it
  burst_trace_fifo #(
    .WIDTH(sync_burst_sram_pkg::DATA_W),
    .DEPTH(sync_burst_sram_pkg::TRACE_DEPTH)
  ) u_trace (
    .clk(clk),
    .srst(srst),
    .inValid(readDone_q),
    .inReady(traceInReady),
    .inData(dataLanesOut),
    .outValid(traceValid),
    .outReady(traceReady),
    .outData(traceData)
  );

endmodule

`default_nettype wire

// ---- dv/sync_burst_sram_port_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_port_monitor (
  // Pins
  input wire logic clk,
  input wire logic srst,
  input wire logic procAddrStrobeN,
  input wire logic ctrlAddrStrobeN,
  input wire logic chipSelOneN,
  input wire logic chipSelTwo,
  input wire logic chipSelThreeN,
  input wire logic byteWriteLaneAN,
  input wire logic byteWriteLaneBN,
  input wire logic globalWriteN,
  input wire logic writeEnableN,
  input wire logic [17:0] dataLanesOut,
  input wire logic dataLanesOe,
  input wire logic outputEnableN,
  // Trace stream
  input wire logic traceInReady,
  input wire logic traceValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic sel = !chipSelOneN && chipSelTwo && !chipSelThreeN;
  wire logic wr = !globalWriteN || !writeEnableN && !(byteWriteLaneAN && byteWriteLaneBN);
  wire logic cStb = !ctrlAddrStrobeN && procAddrStrobeN;
  property p_oe_off; outputEnableN |-> !dataLanesOe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("enable ignored");
  property p_rd; cStb && sel && !wr |-> ##2 dataLanesOe == !outputEnableN; endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_proc; !procAddrStrobeN && sel |-> ##2 dataLanesOe == !outputEnableN; endproperty
  a_proc: assert property (p_proc) else $error("processor read lost");
  property p_wr; cStb && sel && wr |-> ##2 !dataLanesOe; endproperty
  a_wr: assert property (p_wr) else $error("write drove pins");
  property p_desel; cStb && !sel |-> ##2 !dataLanesOe; endproperty
  a_desel: assert property (p_desel) else $error("not deselected");
  // Own disable, since the antecedent is the reset itself
  property p_rst; disable iff (1'b0) srst |=> !dataLanesOe && !traceValid && traceInReady; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_hold; $changed(dataLanesOut) && !outputEnableN |-> dataLanesOe; endproperty
  a_hold: assert property (p_hold) else $error("data moved without read");
  property p_full; !traceInReady |-> traceValid; endproperty
  a_full: assert property (p_full) else $error("full yet empty");
  // A read beat that finds room in the trace buffer must show up there
  property p_push; (cStb && sel && !wr) ##2 traceInReady |=> traceValid; endproperty
  a_push: assert property (p_push) else $error("read beat not traced");
  c_rd: cover property (cStb && sel && !wr);
  c_ign: cover property (!procAddrStrobeN && chipSelOneN);
  c_full: cover property (!traceInReady);
endmodule
`default_nettype wire

// ---- dv/burst_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module burst_master_model (
  input wire logic clk,
  // Pins driven into the port, idle and selected at time zero
  output logic [17:0] addressInputs = 18'h00000,
  output logic procAddrStrobeN = 1'b1,
  output logic ctrlAddrStrobeN = 1'b1,
  output logic burstStepN = 1'b1,
  output logic burstOrderSel = 1'b0,
  output logic chipSelOneN = 1'b0,
  output logic chipSelTwo = 1'b1,
  output logic chipSelThreeN = 1'b0,
  output logic byteWriteLaneAN = 1'b1,
  output logic byteWriteLaneBN = 1'b1,
  output logic globalWriteN = 1'b1,
  output logic writeEnableN = 1'b1,
  output logic [17:0] dataLanesIn = 18'h00000,
  output logic outputEnableN = 1'b1
);
  logic lastWr = 1'b0;
  // Strobes {ctrl, proc, step}, selects {one, two, three}, writes {global, b, a, enable}
  task automatic cyc(input logic [2:0] stb, cs, input logic [3:0] w, input logic [17:0] a, d,
    input logic ord);
    logic wrc;
    wrc = !w[3] || !w[0] && w[2:1] != 2'h3;
    @(posedge clk);
    {ctrlAddrStrobeN, procAddrStrobeN, burstStepN} <= stb;
    {chipSelOneN, chipSelTwo, chipSelThreeN} <= cs;
    {globalWriteN, byteWriteLaneBN, byteWriteLaneAN, writeEnableN} <= w;
    addressInputs <= a;
    burstOrderSel <= ord;
    outputEnableN <= wrc || lastWr;
    lastWr <= wrc;
    // Undriven bus never repeats stale data, so a missed sample shows up
    dataLanesIn <= wrc ? d : ~dataLanesIn;
  endtask
endmodule
`default_nettype wire

// ---- dv/sync_burst_sram_port_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin nCompared++; if ((got) !== (exp)) begin failCount++; \
  $display("unexpected %s exp %h got %h", what, exp, got); end end
module sync_burst_sram_port_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic traceReady = 1'b0;
  logic ord = 1'b0;
  logic [17:0] addressInputs, dataLanesIn, dataLanesOut, traceData;
  logic procAddrStrobeN, ctrlAddrStrobeN, burstStepN, burstOrderSel, chipSelOneN;
  logic chipSelTwo, chipSelThreeN, byteWriteLaneAN, byteWriteLaneBN, globalWriteN;
  logic writeEnableN, dataLanesOe, outputEnableN, traceInReady, traceValid;
  int failCount = 0;
  int nCompared = 0;
  int n;
  logic [1:0] lo;
  logic [3:0] mode [5] = '{4'h7, 4'hc, 4'ha, 4'h9, 4'h8};
  logic [17:0] want [5] = '{18'h3ffff, 18'h001ff, 18'h3fe00, 18'h00000, 18'h3ffff};
  always #25 clk = ~clk;
  sync_burst_sram_port dut (.*);
  burst_master_model pins (.*);
  // One start cycle, one hold cycle, then the word lands after the next edge
  task automatic look(input logic [2:0] stb, cs, input logic [3:0] w, input logic [17:0] a, d,
    exp, input logic oe);
    pins.cyc(stb, cs, w, a, d, ord);
    pins.cyc(3'h7, 3'h2, 4'hf, a, d, ord);
    @(posedge clk);
    #1;
    `CHK("read data", exp, dataLanesOut)
    `CHK("drive", oe, dataLanesOe)
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      pins.cyc(3'h3, 3'h2, 4'h7, 18'h3fffc, 18'h0, ord);
      pins.cyc(3'h3, 3'h2, mode[i], 18'h3fffc, 18'h3ffff, ord);
      look(3'h3, 3'h2, 4'hf, 18'h3fffc, 18'h0, want[i], 1'b1);
    end
    $display("lanes done");
    // Only the first word gets an address; the rest are stepped write beats
    for (int i = 4; i < 8; i++) begin
      pins.cyc(i > 4 ? 3'h6 : 3'h3, 3'h2, 4'h7, 18'(i), 18'(i), ord);
    end
    for (int o = 0; o < 2; o++) begin
      for (int s = 0; s < 4; s++) begin
        ord = o[0];
        pins.cyc(3'h3, 3'h2, 4'hf, 18'(4 + s), 18'h0, ord);
        for (int k = 0; k < 5; k++) begin
          pins.cyc(k < 3 ? 3'h6 : 3'h7, 3'h2, 4'hf, 18'h0, 18'h0, ord);
          #1;
          lo = o ? s[1:0] ^ 2'(k - 1) : s[1:0] + 2'(k - 1);
          if (k > 0) `CHK("burst beat", {16'h1, lo}, dataLanesOut)
        end
      end
    end
    $display("bursts done");
    ord = 1'b0;
    look(3'h5, 3'h2, 4'h7, 18'h5, 18'h3ffff, 18'h5, 1'b0);
    look(3'h4, 3'h6, 4'hf, 18'h5, 18'h0, 18'h6, 1'b1);
    look(3'h3, 3'h3, 4'h7, 18'h5, 18'h0, 18'h6, 1'b0);
    look(3'h3, 3'h0, 4'h7, 18'h5, 18'h0, 18'h6, 1'b0);
    look(3'h3, 3'h6, 4'h7, 18'h5, 18'h0, 18'h6, 1'b0);
    look(3'h3, 3'h2, 4'hf, 18'h5, 18'h0, 18'h5, 1'b1);
    $display("strobes done");
    // Deselect first, or held read beats refill the buffer as fast as it drains
    pins.cyc(3'h3, 3'h0, 4'hf, 18'h0, 18'h0, ord);
    repeat (4) @(posedge clk);
    traceReady <= 1'b1;
    repeat (40) @(posedge clk);
    traceReady <= 1'b0;
    look(3'h3, 3'h2, 4'hf, 18'h5, 18'h0, 18'h5, 1'b1);
    for (n = 0; n < 60 && traceInReady; n++) @(posedge clk);
    `CHK("buffer full", 1'b0, traceInReady)
    if (traceInReady) summarize();
    pins.cyc(3'h3, 3'h0, 4'hf, 18'h0, 18'h0, ord);
    repeat (4) @(posedge clk);
    traceReady <= 1'b1;
    for (n = 0; n < 40; n++) begin
      #1;
      if (!traceValid) break;
      `CHK("trace word", 18'h5, traceData)
      @(posedge clk);
    end
    `CHK("trace count", 32, n)
    $display("trace done");
    summarize();
  end
endmodule
bind sync_burst_sram_port sync_burst_sram_port_monitor mon (.*);
`default_nettype wire
